/* File: hdl/iec_consts.svh */
`ifndef IEC_CONSTS_SVH
`define IEC_CONSTS_SVH

// Register offsets on the serial register port.
`define IEC_OFS_EVT_CFG 8'h34
`define IEC_OFS_EVT_SRC 8'h35
`define IEC_OFS_EVT_THS 8'h36
`define IEC_OFS_EVT_DUR 8'h37
`define IEC_OFS_TAP_CFG 8'h38
`define IEC_OFS_TAP_SRC 8'h39

// Reset values.
`define IEC_RST_BYTE 8'h00
`define IEC_RST_FIELD7 7'h00

// Event configuration fields.
`define IEC_CFG_AND_OR 7
`define IEC_CFG_SIX_DIR 6

// Event source fields.
`define IEC_SRC_ACTIVE 6

// Tap source fields.
`define IEC_TAP_ACTIVE 6
`define IEC_TAP_DOUBLE 5
`define IEC_TAP_SINGLE 4
`define IEC_TAP_SIGN 3

// Boot load time and its length in clock cycles at 50 MHz.
`define IEC_CLK_PERIOD_NS 20
`define IEC_BOOT_TIME_NS 5000
`define IEC_BOOT_CYCLES ((`IEC_BOOT_TIME_NS + `IEC_CLK_PERIOD_NS - 1) / `IEC_CLK_PERIOD_NS)

`endif

/* File: hdl/iec_pkg.sv */
package iec_pkg;

  // Controller state: loading defaults at boot, then normal running.
  typedef enum logic [1:0] {
    IEC_ST_BOOT = 2'b01,
    IEC_ST_RUN = 2'b10
  } iec_state_e;

  // Event mode as {and_or_combine, six_direction_enable}.
  typedef enum logic [1:0] {
    IEC_MODE_OR = 2'b00,
    IEC_MODE_MOVE = 2'b01,
    IEC_MODE_AND = 2'b10,
    IEC_MODE_POS = 2'b11
  } iec_mode_e;

  typedef logic [7:0] iec_byte_t;

endpackage

/* File: hdl/iec_axis_cmp.sv */
`timescale 1ns/1ps

// Compares the magnitude of one axis sample with the threshold.
module iec_axis_cmp #(
  parameter int ACC_W = 12
) (
  // Sample and threshold
  input wire logic signed [ACC_W-1:0] accel_in,
  input wire logic [6:0] ths_in,
  // Comparison results
  output logic above_out,
  output logic below_out,
  output logic positive_out
);

  logic [ACC_W-1:0] mag;
  logic [ACC_W-1:0] ths_ext;

  // The most negative code still fits once taken as unsigned.
  assign mag = accel_in[ACC_W-1] ? (~accel_in + {{(ACC_W-1){1'b0}}, 1'b1}) : accel_in;
  assign ths_ext = {{(ACC_W-7){1'b0}}, ths_in};
  assign above_out = mag > ths_ext;
  assign below_out = mag < ths_ext;
  assign positive_out = ~accel_in[ACC_W-1];

endmodule

/* File: hdl/iec_tap_src.sv */
`timescale 1ns/1ps
`include "iec_consts.svh"

// Tap status flags and the tap interrupt line.
module iec_tap_src (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Detector events
  input wire logic tap_hit_in,
  input wire logic [2:0] tap_axis_in,
  input wire logic tap_negative_in,
  input wire logic tap_latency_done_in,
  input wire logic tap_latch_select_in,
  // Host side
  input wire logic src_read_in,
  // Status
  output logic active_out,
  output logic sign_out,
  output logic [2:0] axis_out,
  output logic tap_irq_out
);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      active_out <= 1'b0;
      tap_irq_out <= 1'b0;
    end
    else if (tap_hit_in)
    begin
      // A new tap wins over a read or a window end in the same cycle.
      active_out <= 1'b1;
      tap_irq_out <= 1'b1;
    end
    else if (src_read_in)
    begin
      active_out <= 1'b0;
      // A window end in the same cycle as a read must still drop the line.
      if (tap_latch_select_in || tap_latency_done_in)
        tap_irq_out <= 1'b0;
    end
    else if (!tap_latch_select_in && tap_latency_done_in)
      tap_irq_out <= 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sign_out <= 1'b0;
      axis_out <= 3'h0;
    end
    else if (tap_hit_in)
    begin
      sign_out <= tap_negative_in;
      axis_out <= tap_axis_in;
    end
    else if (src_read_in)
      axis_out <= 3'h0;
  end

endmodule

/* File: hdl/iec_top.sv */
// Function
// - OR or AND of enabled axis conditions
// - Movement mode pulses one sample on entry
// - Position mode holds while inside zone
// - Above-threshold request per axis when enabled
// - Below-threshold request per axis when enabled
// - Config defaults zero; writes only after boot
// - Status active flag plus per-axis flags
// - Status read-only, top bit reads zero
// - Status read clears active flag and pin
// - Threshold is seven-bit unsigned, default zero
// - Condition must persist N sample periods
// - Per-axis double tap enables, default zero
// - Per-axis single tap enables, default zero
// - Tap active flag at bit six
// - Tap status shows double/single enabled
// - Tap sign: zero positive, one negative
// - Per-axis tap detection flags
// - Tap line held per latch select
`timescale 1ns/1ps
`include "iec_consts.svh"

module iec_top
#(
  parameter int ACC_W = 12,
  parameter int BOOT_CYCLES = `IEC_BOOT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port from the serial interface
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire iec_pkg::iec_byte_t reg_wdata_in,
  input wire logic reg_rd_in,
  output iec_pkg::iec_byte_t reg_rdata_out,
  output logic boot_done_out,
  // Samples at the output sample rate
  input wire logic sample_valid_in,
  input wire logic signed [ACC_W-1:0] accel_x_in,
  input wire logic signed [ACC_W-1:0] accel_y_in,
  input wire logic signed [ACC_W-1:0] accel_z_in,
  input wire logic event_latch_in,
  // Tap detector
  input wire logic tap_detect_in,
  input wire logic tap_double_in,
  input wire logic [2:0] tap_axis_in,
  input wire logic tap_negative_in,
  input wire logic tap_latency_done_in,
  input wire logic tap_latch_select_in,
  // Interrupt lines
  output logic second_irq_pin_out,
  output logic tap_irq_out
);

  import iec_pkg::*;

  localparam int BOOT_W = $clog2(BOOT_CYCLES + 1);
  localparam logic [BOOT_W-1:0] BOOT_LAST = BOOT_W'(BOOT_CYCLES - 1);

  iec_state_e state_r;
  iec_state_e state_nxt;
  logic [BOOT_W-1:0] boot_cnt_r;

  iec_byte_t evt_cfg_r;
  logic [6:0] evt_ths_r;
  logic [6:0] evt_dur_r;
  logic [5:0] tap_cfg_r;

  logic evt_active_r;
  logic [5:0] evt_flags_r;
  logic [7:0] run_cnt_r;
  logic prev_known_r;

  logic [2:0] above;
  logic [2:0] below;
  logic [2:0] positive;
  logic signed [ACC_W-1:0] accel [3];

  logic [5:0] raw_req;
  logic [5:0] zone_req;
  logic [5:0] en_mask;
  logic [5:0] cur_flags;
  logic cond;
  logic recognised;
  logic fire;
  logic [7:0] run_nxt;
  iec_mode_e mode;

  logic wr_ok;
  logic rd_evt_src;
  logic rd_tap_src;
  logic tap_hit;
  logic tap_active;
  logic tap_sign;
  logic [2:0] tap_axis_flags;
  logic dbl_enabled;
  logic sgl_enabled;

  assign accel[0] = accel_x_in;
  assign accel[1] = accel_y_in;
  assign accel[2] = accel_z_in;

  // Boot sequence: configuration holds its defaults until the load is over.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      IEC_ST_BOOT:
      begin
        if (boot_cnt_r == BOOT_LAST)
          state_nxt = IEC_ST_RUN;
      end
      IEC_ST_RUN:
      begin
        state_nxt = IEC_ST_RUN;
      end
      default:
      begin
        state_nxt = IEC_ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state_r <= IEC_ST_BOOT;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      boot_cnt_r <= '0;
    else if (state_r == IEC_ST_BOOT)
      boot_cnt_r <= boot_cnt_r + BOOT_W'(1);
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      boot_done_out <= 1'b0;
    else
      boot_done_out <= (state_nxt == IEC_ST_RUN);
  end

  // Writes during boot are dropped, so a host that writes too early loses them.
  assign wr_ok = reg_wr_in && (state_r == IEC_ST_RUN);
  assign rd_evt_src = reg_rd_in && (reg_addr_in == `IEC_OFS_EVT_SRC);
  assign rd_tap_src = reg_rd_in && (reg_addr_in == `IEC_OFS_TAP_SRC);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      evt_cfg_r <= `IEC_RST_BYTE;
    else if (wr_ok && reg_addr_in == `IEC_OFS_EVT_CFG)
      evt_cfg_r <= reg_wdata_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      evt_ths_r <= `IEC_RST_FIELD7;
    else if (wr_ok && reg_addr_in == `IEC_OFS_EVT_THS)
      evt_ths_r <= reg_wdata_in[6:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      evt_dur_r <= `IEC_RST_FIELD7;
    else if (wr_ok && reg_addr_in == `IEC_OFS_EVT_DUR)
      evt_dur_r <= reg_wdata_in[6:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      tap_cfg_r <= 6'h00;
    else if (wr_ok && reg_addr_in == `IEC_OFS_TAP_CFG)
      tap_cfg_r <= reg_wdata_in[5:0];
  end

  // Per-axis comparison; bit 2*i is the below flag and 2*i+1 the above flag.
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_axis
      iec_axis_cmp #(
        .ACC_W(ACC_W)
      ) u_cmp (
        .accel_in(accel[i]),
        .ths_in(evt_ths_r),
        .above_out(above[i]),
        .below_out(below[i]),
        .positive_out(positive[i])
      );
      assign raw_req[2*i+1] = above[i];
      assign raw_req[2*i] = below[i];
      // A known zone is one axis past the threshold with the other two inside it.
      assign zone_req[2*i+1] = above[i] && positive[i] && (above & ~(3'b001 << i)) == 3'h0;
      assign zone_req[2*i] = above[i] && !positive[i] && (above & ~(3'b001 << i)) == 3'h0;
    end
  endgenerate

  assign en_mask = evt_cfg_r[5:0];
  assign mode = iec_mode_e'({evt_cfg_r[`IEC_CFG_AND_OR], evt_cfg_r[`IEC_CFG_SIX_DIR]});

  always_comb
  begin
    cur_flags = 6'h00;
    cond = 1'b0;
    case (mode)
      IEC_MODE_OR:
      begin
        cur_flags = raw_req & en_mask;
        cond = |cur_flags;
      end
      IEC_MODE_AND:
      begin
        cur_flags = raw_req & en_mask;
        cond = (|en_mask) && ((raw_req | ~en_mask) == 6'h3F);
      end
      IEC_MODE_MOVE, IEC_MODE_POS:
      begin
        cur_flags = zone_req & en_mask;
        cond = |cur_flags;
      end
      default:
      begin
        cur_flags = 6'h00;
        cond = 1'b0;
      end
    endcase
  end

  // Consecutive samples with the condition true, saturating at its top.
  always_comb
  begin
    if (!cond)
      run_nxt = 8'h00;
    else if (run_cnt_r == 8'hFF)
      run_nxt = run_cnt_r;
    else
      run_nxt = run_cnt_r + 8'h01;
  end

  // The condition must have held for at least N earlier periods as well as the current one.
  assign recognised = cond && (run_nxt > {1'b0, evt_dur_r});

  always_comb
  begin
    case (mode)
      IEC_MODE_MOVE:
        fire = recognised && !prev_known_r;
      IEC_MODE_POS:
        fire = recognised;
      default:
        fire = recognised;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      run_cnt_r <= 8'h00;
      prev_known_r <= 1'b0;
    end
    else if (sample_valid_in)
    begin
      run_cnt_r <= run_nxt;
      prev_known_r <= recognised;
    end
  end

  // Event status. Unlatched, every sample rewrites it. Latched, it holds
  // the first event until a status read opens it again.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      evt_active_r <= 1'b0;
      evt_flags_r <= 6'h00;
    end
    else if (sample_valid_in && !event_latch_in)
    begin
      evt_active_r <= fire;
      evt_flags_r <= fire ? cur_flags : 6'h00;
    end
    else if (sample_valid_in && fire && (!evt_active_r || rd_evt_src))
    begin
      evt_active_r <= 1'b1;
      evt_flags_r <= cur_flags;
    end
    else if (rd_evt_src)
    begin
      evt_active_r <= 1'b0;
      if (event_latch_in)
        evt_flags_r <= 6'h00;
    end
  end

  // The pin is its own register updated like the active flag, so a read drops both together.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      second_irq_pin_out <= 1'b0;
    else if (sample_valid_in && (!event_latch_in || !evt_active_r || rd_evt_src))
      second_irq_pin_out <= fire;
    else if (sample_valid_in && event_latch_in && fire)
      second_irq_pin_out <= 1'b1;
    else if (rd_evt_src)
      second_irq_pin_out <= 1'b0;
  end

  // Tap requests pass only on axes whose enable matches the tap kind.
  always_comb
  begin
    tap_hit = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      if (tap_axis_in[k] && tap_cfg_r[2*k + (tap_double_in ? 1 : 0)])
        tap_hit = tap_detect_in;
    end
  end

  assign dbl_enabled = tap_cfg_r[1] | tap_cfg_r[3] | tap_cfg_r[5];
  assign sgl_enabled = tap_cfg_r[0] | tap_cfg_r[2] | tap_cfg_r[4];

  iec_tap_src u_tap (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tap_hit_in(tap_hit),
    .tap_axis_in(tap_axis_in),
    .tap_negative_in(tap_negative_in),
    .tap_latency_done_in(tap_latency_done_in),
    .tap_latch_select_in(tap_latch_select_in),
    .src_read_in(rd_tap_src),
    .active_out(tap_active),
    .sign_out(tap_sign),
    .axis_out(tap_axis_flags),
    .tap_irq_out(tap_irq_out)
  );

  // Read data appears one cycle after the strobe and shows pre-clear status.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= `IEC_RST_BYTE;
    else if (reg_rd_in)
    begin
      if (reg_addr_in == `IEC_OFS_EVT_CFG)
        reg_rdata_out <= evt_cfg_r;
      else if (reg_addr_in == `IEC_OFS_EVT_SRC)
        reg_rdata_out <= {1'b0, evt_active_r, evt_flags_r};
      else if (reg_addr_in == `IEC_OFS_EVT_THS)
        reg_rdata_out <= {1'b0, evt_ths_r};
      else if (reg_addr_in == `IEC_OFS_EVT_DUR)
        reg_rdata_out <= {1'b0, evt_dur_r};
      else if (reg_addr_in == `IEC_OFS_TAP_CFG)
        reg_rdata_out <= {2'b00, tap_cfg_r};
      else if (reg_addr_in == `IEC_OFS_TAP_SRC)
        reg_rdata_out <= {1'b0, tap_active, dbl_enabled, sgl_enabled, tap_sign,
                          tap_axis_flags};
      else
        reg_rdata_out <= `IEC_RST_BYTE;
    end
  end

endmodule

/* File: verif/iec_top_chk.sv */
`timescale 1ns/1ps

module iec_top_chk
#(
  parameter int ACC_W = 12,
  parameter int BOOT_CYCLES = 250
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire iec_pkg::iec_byte_t reg_wdata_in,
  input wire logic reg_rd_in,
  input wire iec_pkg::iec_byte_t reg_rdata_out,
  input wire logic boot_done_out,
  // Samples
  input wire logic sample_valid_in,
  input wire logic signed [ACC_W-1:0] accel_x_in,
  input wire logic signed [ACC_W-1:0] accel_y_in,
  input wire logic signed [ACC_W-1:0] accel_z_in,
  input wire logic event_latch_in,
  // Tap detector
  input wire logic tap_detect_in,
  input wire logic tap_double_in,
  input wire logic [2:0] tap_axis_in,
  input wire logic tap_negative_in,
  input wire logic tap_latency_done_in,
  input wire logic tap_latch_select_in,
  // Interrupt lines
  input wire logic second_irq_pin_out,
  input wire logic tap_irq_out
);
  import iec_pkg::*;

  logic [8:0] boot_cnt_r;
  wire logic evt_rd = reg_rd_in && reg_addr_in == 8'h35;
  wire logic tap_rd = reg_rd_in && reg_addr_in == 8'h39;

  // Saturates so that a long run never wraps back into the boot window.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      boot_cnt_r <= 9'h000;
    else if (boot_cnt_r != 9'h1FF)
      boot_cnt_r <= boot_cnt_r + 9'h001;
  end

  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  chk_boot_busy: assert property (int'(boot_cnt_r) < BOOT_CYCLES - 1 |-> !boot_done_out)
    else $error("boot done too early");
  chk_boot_over: assert property (int'(boot_cnt_r) > BOOT_CYCLES + 1 |-> boot_done_out)
    else $error("boot never ended");
  chk_src_clear: assert property (evt_rd && !sample_valid_in |=> !second_irq_pin_out)
    else $error("status read left pin high");
  chk_src_active: assert property (evt_rd |=> reg_rdata_out[6] == $past(second_irq_pin_out))
    else $error("active flag differs from pin");
  chk_src_msb: assert property (evt_rd || tap_rd |=> !reg_rdata_out[7])
    else $error("status top bit set");
  chk_pin_cause: assert property (!$stable(second_irq_pin_out) |->
    $past(sample_valid_in) || $past(evt_rd) || $past(rst_in))
    else $error("pin moved without sample or read");
  chk_tap_read: assert property (tap_latch_select_in && tap_rd && !tap_detect_in
    |=> !tap_irq_out)
    else $error("latched tap line kept after read");
  chk_tap_window: assert property (!tap_latch_select_in && tap_latency_done_in
    && !tap_detect_in |=> !tap_irq_out)
    else $error("tap line kept after latency end");
  chk_tap_hold: assert property (tap_irq_out && !tap_latency_done_in && !tap_rd
    |=> tap_irq_out)
    else $error("tap line dropped early");
endmodule

bind iec_top iec_top_chk #(
  .ACC_W(ACC_W),
  .BOOT_CYCLES(BOOT_CYCLES)
) chk_u (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .boot_done_out(boot_done_out),
  .sample_valid_in(sample_valid_in),
  .accel_x_in(accel_x_in),
  .accel_y_in(accel_y_in),
  .accel_z_in(accel_z_in),
  .event_latch_in(event_latch_in),
  .tap_detect_in(tap_detect_in),
  .tap_double_in(tap_double_in),
  .tap_axis_in(tap_axis_in),
  .tap_negative_in(tap_negative_in),
  .tap_latency_done_in(tap_latency_done_in),
  .tap_latch_select_in(tap_latch_select_in),
  .second_irq_pin_out(second_irq_pin_out),
  .tap_irq_out(tap_irq_out)
);

/* File: verif/iec_host_model.sv */
`timescale 1ns/1ps

module iec_host_model (
  // Clock and boot status
  input wire logic clk_in,
  input wire logic boot_done_in,
  // Register port requests
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out
);
  initial
  begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
  end

  // Idle lines show the inverse of the last access so stale values never match.
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = w;
    reg_rd_out = !w;
    @(negedge clk_in);
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask

  task automatic wait_boot(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 600 && !ok; i++)
    begin
      @(negedge clk_in);
      ok = boot_done_in;
    end
  endtask
endmodule

/* File: verif/tb_inertial_event_and_click_irq.sv */
`timescale 1ns/1ps

module tb_inertial_event_and_click_irq;
  import iec_pkg::*;
  localparam int BC = 4;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in;
  logic reg_wr_in, reg_rd_in, boot_done_out, second_irq_pin_out, tap_irq_out;
  iec_byte_t reg_wdata_in, reg_rdata_out;
  logic sample_valid_in = 1'b0;
  logic event_latch_in = 1'b0;
  logic signed [11:0] accel_x_in = '0, accel_y_in = '0, accel_z_in = '0;
  logic tap_detect_in = 1'b0, tap_double_in = 1'b0, tap_negative_in = 1'b0;
  logic tap_latency_done_in = 1'b0, tap_latch_select_in = 1'b0;
  logic [2:0] tap_axis_in = 3'h0;
  int num_errors = 0;
  int tests_run = 0;
  iec_byte_t exp_q[$];

  iec_top #(
    .BOOT_CYCLES(BC)
  ) dut_u (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .boot_done_out(boot_done_out),
    .sample_valid_in(sample_valid_in),
    .accel_x_in(accel_x_in),
    .accel_y_in(accel_y_in),
    .accel_z_in(accel_z_in),
    .event_latch_in(event_latch_in),
    .tap_detect_in(tap_detect_in),
    .tap_double_in(tap_double_in),
    .tap_axis_in(tap_axis_in),
    .tap_negative_in(tap_negative_in),
    .tap_latency_done_in(tap_latency_done_in),
    .tap_latch_select_in(tap_latch_select_in),
    .second_irq_pin_out(second_irq_pin_out),
    .tap_irq_out(tap_irq_out)
  );
  iec_host_model host_u (
    .clk_in(clk_in),
    .boot_done_in(boot_done_out),
    .reg_addr_out(reg_addr_in),
    .reg_wr_out(reg_wr_in),
    .reg_wdata_out(reg_wdata_in),
    .reg_rd_out(reg_rd_in)
  );

  initial
  begin
    forever #10 clk_in = ~clk_in;
  end

  task automatic check_val(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // An empty queue compares against the inverse, so a stray read is a mismatch.
  always @(posedge clk_in)
  begin
    if (reg_rd_in === 1'b1)
    begin
      #1;
      check_val(reg_rdata_out, exp_q.size() ? exp_q.pop_front() : ~reg_rdata_out);
    end
  end

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.acc(a, 8'h00, 1'b0);
  endtask

  task automatic pin(input logic e);
    check_val(8'(second_irq_pin_out), 8'(e));
  endtask

  task automatic smp(input logic signed [11:0] x, y, z, input logic e);
    @(negedge clk_in);
    sample_valid_in = 1'b1;
    accel_x_in = x;
    accel_y_in = y;
    accel_z_in = z;
    @(negedge clk_in);
    sample_valid_in = 1'b0;
    pin(e);
  endtask

  task automatic tap(input logic [2:0] ax, input logic dbl, neg, e);
    @(negedge clk_in);
    tap_detect_in = 1'b1;
    tap_axis_in = ax;
    tap_double_in = dbl;
    tap_negative_in = neg;
    @(negedge clk_in);
    tap_detect_in = 1'b0;
    check_val(8'(tap_irq_out), 8'(e));
  endtask

  initial
  begin
    bit ok;
    int i;
    logic signed [11:0] v;
    logic signed [11:0] s[3];
    void'($urandom(28));
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    host_u.acc(8'h34, 8'hFF, 1'b1);
    host_u.wait_boot(ok);
    check_val(8'(ok), 8'h01);
    if (!ok)
      wrap_up();
    for (i = 0; i < 6; i++)
      rd(8'h34 + 8'(i), 8'h00);
    rd(8'h20, 8'h00);
    host_u.acc(8'h36, 8'h05, 1'b1);
    host_u.acc(8'h35, 8'hFF, 1'b1);
    rd(8'h36, 8'h05);
    rd(8'h35, 8'h00);
    for (i = 0; i < 6; i++)
    begin
      host_u.acc(8'h34, 8'(1 << i), 1'b1);
      v = (i % 2) ? 12'(6 + $urandom % 50) : 12'($urandom % 5);
      if ($urandom % 2)
        v = -v;
      s = '{12'sd5, 12'sd5, 12'sd5};
      s[i / 2] = v;
      smp(s[0], s[1], s[2], 1'b1);
      rd(8'h35, 8'h40 | 8'(1 << i));
      pin(1'b0);
      smp(12'sd5, 12'sd5, 12'sd5, 1'b0);
    end
    host_u.acc(8'h34, 8'h02, 1'b1);
    host_u.acc(8'h37, 8'h02, 1'b1);
    for (i = 0; i < 6; i++)
      smp(i == 2 ? 12'sd5 : 12'sd9, 12'sd5, 12'sd5, i == 5);
    host_u.acc(8'h37, 8'h00, 1'b1);
    host_u.acc(8'h34, 8'h8A, 1'b1);
    smp(12'sd9, 12'sd2, 12'sd5, 1'b0);
    smp(12'sd9, 12'sd9, 12'sd5, 1'b1);
    rd(8'h35, 8'h4A);
    event_latch_in = 1'b1;
    host_u.acc(8'h34, 8'h02, 1'b1);
    smp(12'sd9, 12'sd5, 12'sd5, 1'b1);
    smp(12'sd5, 12'sd5, 12'sd5, 1'b1);
    rd(8'h35, 8'h42);
    pin(1'b0);
    smp(12'sd5, 12'sd5, 12'sd5, 1'b0);
    rd(8'h35, 8'h00);
    event_latch_in = 1'b0;
    host_u.acc(8'h34, 8'h7F, 1'b1);
    smp(12'sd5, 12'sd5, 12'sd5, 1'b0);
    smp(12'sd9, 12'sd5, 12'sd5, 1'b1);
    smp(12'sd9, 12'sd5, 12'sd5, 1'b0);
    host_u.acc(8'h34, 8'hFF, 1'b1);
    smp(12'sd5, 12'sd5, -12'sd9, 1'b1);
    rd(8'h35, 8'h50);
    smp(12'sd5, 12'sd5, -12'sd9, 1'b1);
    smp(12'sd5, 12'sd5, 12'sd5, 1'b0);
    tap_latch_select_in = 1'b1;
    host_u.acc(8'h38, 8'h3F, 1'b1);
    rd(8'h39, 8'h30);
    tap(3'h1, 1'b0, 1'b1, 1'b1);
    rd(8'h39, 8'h79);
    check_val(8'(tap_irq_out), 8'h00);
    host_u.acc(8'h38, 8'h05, 1'b1);
    tap_latch_select_in = 1'b0;
    tap(3'h1, 1'b1, 1'b0, 1'b0);
    tap(3'h4, 1'b0, 1'b0, 1'b0);
    tap(3'h2, 1'b0, 1'b0, 1'b1);
    rd(8'h39, 8'h52);
    check_val(8'(tap_irq_out), 8'h01);
    @(negedge clk_in);
    tap_latency_done_in = 1'b1;
    @(negedge clk_in);
    tap_latency_done_in = 1'b0;
    check_val(8'(tap_irq_out), 8'h00);
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    rd(8'h34, 8'h00);
    repeat (4) @(negedge clk_in);
    wrap_up();
  end
endmodule
